// File: design/alu_core.sv
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// Function
// RL1: 11 110x word subtracts accumulator from literal; updates carry, half-carry, zero.
// RL2: 11 1010 word XORs literal into accumulator; one cycle; only zero flag.
// RL3: read-modify-write of the I/O port uses sampled pin levels, not the latch.
// RL4: timer count written back to file clears prescaler when assigned to timer.
// RL5: program-counter changes or true tests take two cycles; second is a no-op.
// RL6: add literal to accumulator; result to accumulator; carry, half-carry, zero.
// RL7: AND accumulator with file 0..127; chosen destination; only zero flag.
// RL8: destination bit 0 writes accumulator, 1 writes the file register.
// RL9: add accumulator and file 0..127; chosen destination; carry, half-carry, zero.
// RL10: bit clear forces selected bit 0..7 of file low; no flags.
// RL11: bit set forces selected bit 0..7 of file high; no flags.
// RL12: AND literal into accumulator; result to accumulator; only zero flag.
// RL13: zero on zero result, carry from bit 7, half from bit 3, not-borrow.
// RL14: single-cycle ops take one cycle, touching only destination and listed flags.
module alu_core
   import alu_ops_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  port_pin,
   output logic      [7:0]  port_out,
   output logic             prescaler_clear,
   output logic             busy
);

   core_state_t state;
   core_state_t next_state;

   logic [13:0] instr;
   logic [7:0]  acc;
   logic        carry;
   logic        half;
   logic        zero;
   logic        presc_tmr;
   logic [12:0] program_counter;
   logic [6:0]  file_addr;
   logic [7:0]  pin_s1;
   logic [7:0]  pin_s2;
   logic [7:0]  pin_s3;
   logic [7:0]  pin_level;

   // ---------------- decode ----------------
   wire logic is_sub_lit  = instr[13:9] == OPC_SUB_LIT;
   wire logic is_add_lit  = instr[13:9] == OPC_ADD_LIT;
   wire logic is_xor_lit  = instr[13:8] == OPC_XOR_LIT;
   wire logic is_and_lit  = instr[13:8] == OPC_AND_LIT;
   wire logic is_and_file = instr[13:8] == OPC_AND_FILE;
   wire logic is_add_file = instr[13:8] == OPC_ADD_FILE;
   wire logic is_bit_clr  = instr[13:10] == OPC_BIT_CLR;
   wire logic is_bit_set  = instr[13:10] == OPC_BIT_SET;
   wire logic is_branch   = instr[13:12] == OPC_BRANCH;

   wire logic is_literal  = is_sub_lit | is_add_lit | is_xor_lit | is_and_lit;
   wire logic is_arith_f  = is_and_file | is_add_file;
   wire logic is_bit_op   = is_bit_clr | is_bit_set;
   wire logic dest_file   = instr[DEST_POS];
   wire logic [6:0] f_addr = instr[6:0];
   wire logic [7:0] literal = instr[7:0];

   wire logic writes_file = (is_arith_f & dest_file) | is_bit_op;                      // RL8
   wire logic writes_acc  = is_literal | (is_arith_f & ~dest_file);                    // RL8

   // ---------------- operand selection ----------------
   wire logic [7:0] ram_rdata;
   wire logic [7:0] file_operand;
   // a port operand comes from the pins, so a pin held low by the outside
   // world is written back low even when its latch holds a one
   assign file_operand = (f_addr == PORT_ADDR) ? pin_level : ram_rdata;            // RL3

   alu_op_t     alu_op;
   wire logic [7:0] alu_b;
   wire logic [7:0] alu_result;
   wire logic       alu_carry;
   wire logic       alu_half;
   wire logic       alu_zero;

   assign alu_op = is_sub_lit                ? ALU_SUB :                           // RL1
                   (is_add_lit | is_add_file) ? ALU_ADD :                          // RL6 RL9
                   is_xor_lit                ? ALU_XOR :                           // RL2
                   (is_and_lit | is_and_file) ? ALU_AND :                          // RL7 RL12
                   is_bit_clr                ? ALU_BCL :                           // RL10
                   is_bit_set                ? ALU_BST :                           // RL11
                                               ALU_PAS;
   assign alu_b = is_literal ? literal : file_operand;

   byte_alu u_alu (
      .op      (alu_op),
      .a       (acc),
      .b       (alu_b),
      .bit_sel (instr[BIT_LSB+2:BIT_LSB]),
      .result  (alu_result),
      .carry   (alu_carry),
      .half    (alu_half),
      .zero    (alu_zero)
   );

   wire logic upd_c_dc = is_sub_lit | is_add_lit | is_add_file;                    // RL13
   wire logic upd_z    = upd_c_dc | is_xor_lit | is_and_lit | is_and_file;        // RL13

   // ---------------- bus decode ----------------
   wire logic access    = psel & penable;
   wire logic hit_instr = paddr == REG_INSTR;
   wire logic hit_acc   = paddr == REG_ACC;
   wire logic hit_stat  = paddr == REG_STATUS;
   wire logic hit_cfg   = paddr == REG_CONFIG;
   wire logic hit_pc    = paddr == REG_PC;
   wire logic hit_faddr = paddr == REG_FADDR;
   wire logic hit_fdata = paddr == REG_FDATA;
   wire logic mapped    = hit_instr | hit_acc | hit_stat | hit_cfg | hit_pc | hit_faddr | hit_fdata;
   wire logic idle      = state == ST_IDLE;

   // writes and file-data reads wait until the core is idle, so software
   // never races an instruction that is still touching the same state
   wire logic fdata_rd  = access & ~pwrite & hit_fdata & mapped;
   assign pready = fdata_rd ? (state == ST_RDWAIT) :
                   (access & pwrite & mapped) ? idle : 1'b1;
   assign pslverr = access & ~mapped;

   wire logic bus_wr    = access & pwrite & idle & mapped;
   wire logic start     = bus_wr & hit_instr;
   wire logic wr_stat   = bus_wr & hit_stat;
   wire logic wr_cfg    = bus_wr & hit_cfg;
   wire logic wr_pc     = bus_wr & hit_pc;
   wire logic wr_faddr  = bus_wr & hit_faddr;

   wire logic [31:0] status_word = {28'h0000000, ~idle, zero, half, carry};
   wire logic [31:0] rd_instr    = {18'h00000, instr};
   wire logic [31:0] rd_acc      = {24'h000000, acc};
   wire logic [31:0] rd_cfg      = {31'h00000000, presc_tmr};
   wire logic [31:0] rd_pc       = {19'h00000, program_counter};
   wire logic [31:0] rd_faddr    = {25'h0000000, file_addr};
   wire logic [31:0] rd_fdata    = {24'h000000, ram_rdata};
   // outside a read access the data lines rest at zero
   assign prdata = (~access | pwrite)  ? 32'h00000000 :
                   hit_instr ? rd_instr :
                   hit_acc   ? rd_acc :
                   hit_stat  ? status_word :
                   hit_cfg   ? rd_cfg :
                   hit_pc    ? rd_pc :
                   hit_faddr ? rd_faddr :
                   hit_fdata ? rd_fdata :
                               32'h00000000;

   // ---------------- file store ----------------
   // the file byte is read at the fetch edge and stands registered during exec;
   // while idle the store belongs to the bus and follows the software address
   wire logic exec       = state == ST_EXEC;
   wire logic core_fwr   = exec & writes_file;                                     // RL8
   wire logic bus_fwr    = bus_wr & hit_fdata;
   wire logic ram_we     = core_fwr | bus_fwr;
   wire logic [6:0] ram_addr  = idle ? file_addr : f_addr;
   wire logic [7:0] ram_wdata = idle ? pwdata[7:0] : alu_result;

   file_ram u_ram (
      .mclk  (mclk),
      .we    (ram_we),
      .addr  (ram_addr),
      .wdata (ram_wdata),
      .rdata (ram_rdata)
   );

   // ---------------- sequencing ----------------
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (start)
               next_state = ST_FETCH;
            else if (fdata_rd)
               next_state = ST_RDWAIT;
         end
         ST_FETCH:
            next_state = ST_EXEC;
         ST_EXEC:
            next_state = is_branch ? ST_NOP : ST_IDLE;                              // RL5 RL14
         ST_NOP:
            next_state = ST_IDLE;                                                   // RL5
         ST_RDWAIT:
            next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // ---------------- pin sampling ----------------
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_s1 <= 8'h00;
         pin_s2 <= 8'h00;
         pin_s3 <= 8'h00;
      end
      else
      begin
         pin_s1 <= port_pin;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // a pin change is taken only once two stages agree, so a level caught
   // mid-transition never reaches an instruction operand
   wire logic [7:0] next_pin_level = (pin_s2 == pin_s3) ? pin_s3 : pin_level;    // RL3

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         pin_level <= 8'h00;
      else
         pin_level <= next_pin_level;
   end

   // ---------------- architectural registers ----------------
   wire logic [7:0] next_acc = (exec & writes_acc) ? alu_result :                  // RL8
                               (bus_wr & hit_acc) ? pwdata[7:0] : acc;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         acc <= ACC_RST;
      else
         acc <= next_acc;
   end

   // flags move only for the instructions that list them; a status write
   // can never meet an instruction in one cycle, as writes wait for idle
   wire logic next_carry = (exec & upd_c_dc) ? alu_carry :                          // RL13
                           wr_stat ? pwdata[ST_CARRY] : carry;
   wire logic next_half  = (exec & upd_c_dc) ? alu_half :                           // RL13
                           wr_stat ? pwdata[ST_HALF] : half;
   wire logic next_zero  = (exec & upd_z) ? alu_zero :                              // RL13
                           wr_stat ? pwdata[ST_ZERO] : zero;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         carry <= 1'b0;
      else
         carry <= next_carry;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         half <= 1'b0;
      else
         half <= next_half;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         zero <= 1'b0;
      else
         zero <= next_zero;
   end

   wire logic [13:0] next_instr     = start ? pwdata[13:0] : instr;
   wire logic        next_presc_tmr = wr_cfg ? pwdata[CFG_PRESC_TMR] : presc_tmr;
   wire logic [6:0]  next_file_addr = wr_faddr ? pwdata[6:0] : file_addr;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         instr <= 14'h0000;
      else
         instr <= next_instr;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         presc_tmr <= 1'b0;
      else
         presc_tmr <= next_presc_tmr;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         file_addr <= 7'h00;
      else
         file_addr <= next_file_addr;
   end

   // branches load the target; other instructions step by one, and a PC write loads the bus data
   wire logic [12:0] next_program_counter = (exec & is_branch) ? {2'b00, instr[10:0]} :      // RL5
                                            exec  ? program_counter + 13'h0001 :
                                            wr_pc ? pwdata[12:0] : program_counter;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         program_counter <= PC_RST;
      else
         program_counter <= next_program_counter;
   end

   // the port latch mirrors whatever lands at the port address, from the
   // bus or from an instruction, so latch and file byte agree from the first port write after reset
   wire logic       port_we       = ram_we & (ram_addr == PORT_ADDR);
   wire logic [7:0] next_port_out = port_we ? ram_wdata : port_out;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         port_out <= PORT_RST;
      else
         port_out <= next_port_out;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         prescaler_clear <= 1'b0;
      else
         prescaler_clear <= core_fwr & (f_addr == TIMER_ADDR) & presc_tmr;          // RL4
   end

   assign busy = ~idle;

endmodule

// File: design/alu_ops_pkg.sv
package alu_ops_pkg;

   // instruction word and operand layout
   localparam int INSTR_W        = 14;
   localparam int DATA_W         = 8;
   localparam int FADDR_W        = 7;
   localparam int PC_W           = 13;
   localparam int FILE_DEPTH     = 128;
   localparam int DEST_POS       = 7;
   localparam int BIT_LSB        = 7;

   // opcode fields, compared against the word's upper bits
   localparam logic [4:0] OPC_SUB_LIT  = 5'h1E;   // 11 110x
   localparam logic [4:0] OPC_ADD_LIT  = 5'h1F;   // 11 111x
   localparam logic [5:0] OPC_XOR_LIT  = 6'h3A;   // 11 1010
   localparam logic [5:0] OPC_AND_LIT  = 6'h39;   // 11 1001
   localparam logic [5:0] OPC_AND_FILE = 6'h05;   // 00 0101
   localparam logic [5:0] OPC_ADD_FILE = 6'h07;   // 00 0111
   localparam logic [3:0] OPC_BIT_CLR  = 4'h4;    // 01 00
   localparam logic [3:0] OPC_BIT_SET  = 4'h5;    // 01 01
   localparam logic [1:0] OPC_BRANCH   = 2'h2;    // 10 xxxx

   // file addresses with side effects
   localparam logic [6:0] TIMER_ADDR   = 7'h01;
   localparam logic [6:0] PORT_ADDR    = 7'h06;

   // register map, byte addresses
   localparam logic [7:0] REG_INSTR    = 8'h00;
   localparam logic [7:0] REG_ACC      = 8'h04;
   localparam logic [7:0] REG_STATUS   = 8'h08;
   localparam logic [7:0] REG_CONFIG   = 8'h0C;
   localparam logic [7:0] REG_PC       = 8'h10;
   localparam logic [7:0] REG_FADDR    = 8'h14;
   localparam logic [7:0] REG_FDATA    = 8'h18;

   // status and config fields
   localparam int ST_CARRY       = 0;
   localparam int ST_HALF        = 1;
   localparam int ST_ZERO        = 2;
   localparam int ST_BUSY        = 3;
   localparam int CFG_PRESC_TMR  = 0;

   // reset values
   localparam logic [7:0]  ACC_RST     = 8'h00;
   localparam logic [12:0] PC_RST      = 13'h0000;
   localparam logic [7:0]  PORT_RST    = 8'h00;

   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_FETCH  = 5'b00010,
      ST_EXEC   = 5'b00100,
      ST_NOP    = 5'b01000,
      ST_RDWAIT = 5'b10000
   } core_state_t;

   typedef enum logic [2:0] {
      ALU_ADD = 3'h0,
      ALU_SUB = 3'h1,
      ALU_AND = 3'h2,
      ALU_XOR = 3'h3,
      ALU_BCL = 3'h4,
      ALU_BST = 3'h5,
      ALU_PAS = 3'h6
   } alu_op_t;

endpackage

// File: design/file_ram.sv
`timescale 1ns/1ps

// single-port file register store; read data is registered
module file_ram
   import alu_ops_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = FILE_DEPTH,
   parameter int AW    = FADDR_W
)(
   input  wire logic             mclk,
   input  wire logic             we,
   input  wire logic [AW-1:0]    addr,
   input  wire logic [WIDTH-1:0] wdata,
   output logic      [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge mclk)
   begin
      if (we)
         mem[addr] <= wdata;
      rdata <= mem[addr];
   end

endmodule

// File: design/byte_alu.sv
`timescale 1ns/1ps

module byte_alu
   import alu_ops_pkg::*;
(
   input  wire alu_op_t    op,
   input  wire logic [7:0] a,
   input  wire logic [7:0] b,
   input  wire logic [2:0] bit_sel,
   output logic      [7:0] result,
   output logic            carry,
   output logic            half,
   output logic            zero
);

   // returns {carry7, carry3, sum}
   function automatic logic [9:0] add8(input logic [7:0] x, input logic [7:0] y, input logic cin);
      logic [4:0] lo;
      logic [4:0] hi;
      lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
      hi = {1'b0, x[7:4]} + {1'b0, y[7:4]} + {4'h0, lo[4]};
      return {hi[4], lo[4], hi[3:0], lo[3:0]};
   endfunction

   wire logic [9:0] sum_add = add8(a, b, 1'b0);
   // b minus a as b + ~a + 1, so carry reads as not-borrow
   wire logic [9:0] sum_sub = add8(b, ~a, 1'b1);
   wire logic [7:0] one_hot = 8'h01 << bit_sel;

   always_comb
   begin
      result = b;
      carry  = 1'b0;
      half   = 1'b0;
      case (op)
         ALU_ADD:
         begin
            result = sum_add[7:0];
            carry  = sum_add[9];
            half   = sum_add[8];
         end
         ALU_SUB:
         begin
            result = sum_sub[7:0];
            carry  = sum_sub[9];
            half   = sum_sub[8];
         end
         ALU_AND: result = a & b;
         ALU_XOR: result = a ^ b;
         ALU_BCL: result = b & ~one_hot;
         ALU_BST: result = b | one_hot;
         default: result = b;
      endcase
   end

   assign zero = (result == 8'h00);

endmodule

// File: test/alu_core_asserts.sv
`timescale 1ns/1ps

module alu_core_asserts
   import alu_ops_pkg::*;
(
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  port_pin,
   input wire logic [7:0]  port_out,
   input wire logic        prescaler_clear,
   input wire logic        busy
);
   default clocking dclk @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   wire xfer   = psel && penable && pready;
   wire mapped = (paddr <= REG_FDATA) && (paddr[1:0] == 2'h0);
   wire go     = xfer && pwrite && (paddr == REG_INSTR);
   wire jump   = (pwdata[13:12] == OPC_BRANCH);

   a_single_cycle: assert property (go && !jump |=> busy [*2] ##1 !busy)
      else $error("plain instruction length wrong");
   a_branch_nop: assert property (go && jump |=> busy [*3] ##1 !busy)
      else $error("branch length wrong");
   a_unmapped_err: assert property (psel && penable && !mapped |-> pready && pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
      else $error("mapped access refused");
   a_write_held: assert property (psel && penable && pwrite && mapped && busy |-> !pready)
      else $error("write taken while busy");
   a_clear_pulse: assert property (prescaler_clear |=> !prescaler_clear)
      else $error("prescaler clear longer than one cycle");
   a_clear_cause: assert property (prescaler_clear |-> $past(busy))
      else $error("prescaler clear without instruction");
   a_port_cause: assert property (!$stable(port_out) |-> $past(busy) || $past(go || xfer && pwrite && paddr == REG_FDATA))
      else $error("port latch changed without cause");
endmodule

bind alu_core alu_core_asserts u_asserts (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .port_pin, .port_out, .prescaler_clear, .busy);

// File: test/testbench.sv
`timescale 1ns/1ps

module testbench;
   import alu_ops_pkg::*;
   logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, prescaler_clear, busy;
   logic [7:0]  paddr, port_pin, port_out;
   logic [31:0] pwdata, prdata, rd;
   int          fail_count, total_checks, busy_cycles;
   logic        pulse, err;

   alu_core DUT (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_pin(port_pin), .port_out(port_out), .prescaler_clear(prescaler_clear), .busy(busy));

   initial
   begin
      mclk = 0;
      forever #10 mclk = ~mclk;
   end

   task conclude;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one idle cycle before each setup keeps every signal to one assignment per step
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end while (pready !== 1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (pready !== 1)
      begin
         fail_count++;
         conclude();
      end
   endtask

   task exec(input logic [13:0] w);
      apb(1, REG_INSTR, {18'h0, w});
      busy_cycles = 0;
      pulse = 0;
      repeat (10)
      begin
         @(posedge mclk);
         if (busy === 1) busy_cycles++;
         if (prescaler_clear === 1) pulse = 1;
      end
   endtask

   task test_reset;
      apb(0, REG_ACC, 0);    check(rd, 0);
      apb(0, REG_STATUS, 0); check(rd, 0);
      apb(0, REG_PC, 0);     check(rd, 0);
      apb(0, REG_CONFIG, 0); check(rd, 0);
      apb(1, 8'h1C, 32'hFF); check(err, 1);
      apb(0, 8'h1C, 0);      check(err, 1);
      check(rd, 0);
      check(port_out, PORT_RST);
      $display("test reset done");
   endtask

   task lit_case(input logic [13:0] w, input logic [7:0] a0, input logic [2:0] s0,
                 input logic [7:0] ax, input logic [2:0] sx);
      apb(1, REG_ACC, a0);
      apb(1, REG_STATUS, s0);
      exec(w);
      check(busy_cycles, 2);
      apb(0, REG_ACC, 0);    check(rd, ax);
      apb(0, REG_STATUS, 0); check(rd, sx);
   endtask

   task test_literal;
      lit_case(14'h3C03, 8'h05, 3'h0, 8'hFE, 3'h0);
      lit_case(14'h3D03, 8'h03, 3'h0, 8'h00, 3'h7);
      lit_case(14'h3E01, 8'hFF, 3'h0, 8'h00, 3'h7);
      lit_case(14'h3F08, 8'h08, 3'h4, 8'h10, 3'h2);
      lit_case(14'h3A5A, 8'h5A, 3'h3, 8'h00, 3'h7);
      lit_case(14'h390F, 8'hF0, 3'h1, 8'h00, 3'h5);
      lit_case(14'h39FF, 8'hFF, 3'h6, 8'hFF, 3'h2);
      $display("test literal done");
   endtask

   task file_case(input logic [13:0] w, input logic [7:0] fv, input logic [7:0] a0, input logic [2:0] s0,
                  input logic [7:0] ax, input logic [7:0] fx, input logic [2:0] sx);
      apb(1, REG_FADDR, w[6:0]);
      apb(1, REG_FDATA, fv);
      apb(1, REG_ACC, a0);
      apb(1, REG_STATUS, s0);
      exec(w);
      apb(0, REG_ACC, 0);    check(rd, ax);
      apb(0, REG_FDATA, 0);  check(rd, fx);
      apb(0, REG_STATUS, 0); check(rd, sx);
   endtask

   task test_file;
      file_case(14'h057F, 8'h3C, 8'h0F, 3'h3, 8'h0C, 8'h3C, 3'h3);
      file_case(14'h05A0, 8'hF0, 8'h0F, 3'h0, 8'h0F, 8'h00, 3'h4);
      file_case(14'h0700, 8'h80, 8'h80, 3'h0, 8'h00, 8'h80, 3'h5);
      file_case(14'h07A1, 8'h0F, 8'h01, 3'h0, 8'h01, 8'h10, 3'h2);
      file_case(14'h13A2, 8'hFF, 8'h11, 3'h5, 8'h11, 8'h7F, 3'h5);
      file_case(14'h1423, 8'h00, 8'h22, 3'h2, 8'h22, 8'h01, 3'h2);
      $display("test file done");
   endtask

   task test_port;
      apb(1, REG_FADDR, PORT_ADDR);
      apb(1, REG_FDATA, 8'hFF);
      @(posedge mclk);
      check(port_out, 8'hFF);
      port_pin <= 8'h0F;
      repeat (6) @(posedge mclk);
      exec(14'h1006);
      check(port_out, 8'h0E);
      apb(0, REG_FDATA, 0); check(rd, 8'h0E);
      $display("test port done");
   endtask

   task test_prescaler;
      apb(1, REG_FADDR, TIMER_ADDR);
      apb(1, REG_FDATA, 8'h10);
      apb(1, REG_CONFIG, 1);
      exec(14'h0781); check(pulse, 1);
      apb(0, REG_FDATA, 0); check(rd, 8'h32);
      exec(14'h0701); check(pulse, 0);
      apb(1, REG_CONFIG, 0);
      exec(14'h0781); check(pulse, 0);
      $display("test prescaler done");
   endtask

   task test_branch;
      exec(14'h27FF);
      check(busy_cycles, 3);
      apb(0, REG_PC, 0); check(rd, 32'h7FF);
      $display("test branch done");
   endtask

   // a write issued straight after an instruction must wait until the core is idle
   task test_held;
      apb(1, REG_INSTR, {18'h0, 14'h27FF});
      apb(1, REG_ACC, 32'h5A);
      check(busy, 0);
      apb(0, REG_ACC, 0); check(rd, 8'h5A);
      $display("test held done");
   endtask

   initial
   begin
      fail_count = 0;
      total_checks = 0;
      resetn = 0;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      port_pin = 0;
      repeat (2) @(posedge mclk);
      resetn <= 1;
      test_reset();
      test_literal();
      test_file();
      test_port();
      test_prescaler();
      test_branch();
      test_held();
      conclude();
   end
endmodule
